// ===== rtl/i2c_slave_port.v
`timescale 1ns/1ps
`include "i2c_port_map.vh"

// Two-wire slave port giving a master access to eight byte-wide registers.
module i2c_slave_port (
	input  wire       clk_sys,       // System clock, 25 MHz.
	input  wire       nrst,          // Asynchronous reset, active low.
	input  wire       scl_in,        // Serial clock pin level.
	input  wire       sda_in,        // Serial data pin level.
	output reg        sda_out,       // Serial data drive level, always low.
	output reg        sda_oe,        // Serial data pull-down enable.
	input  wire       addr_strap_hi, // Upper address select strap.
	input  wire       addr_strap_lo, // Lower address select strap.
	output reg  [2:0] reg_sel,       // Selected register index.
	output reg  [7:0] wr_data,       // Byte being written.
	output reg        wr_stb,        // One-cycle write strobe.
	input  wire       wr_ready,      // Register side can take a byte.
	output reg        rd_stb,        // One-cycle read request.
	input  wire [7:0] rd_data,       // Read byte, valid two cycles after rd_stb.
	output reg        bus_busy,      // Bus occupied between start and stop.
	output reg        addressed,     // This slave was selected in the transaction.
	output reg        sub_pad_err    // Last subaddress had nonzero low bits.
);

	// Transaction states.
	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_ADDR   = 3'h1;
	localparam [2:0] ST_SUB    = 3'h2;
	localparam [2:0] ST_WDATA  = 3'h3;
	localparam [2:0] ST_RDATA  = 3'h4;
	localparam [2:0] ST_IGNORE = 3'h5;

	// Acknowledge slot phases.
	localparam [1:0] SL_DATA   = 2'h0;
	localparam [1:0] SL_LOW    = 2'h1;
	localparam [1:0] SL_HIGH   = 2'h2;

	wire [3:0] pins_sync;
	wire       scl_s;
	wire       sda_s;
	wire       strap_hi_s;
	wire       strap_lo_s;

	reg        scl_q;
	reg        sda_q;
	reg  [2:0] state;
	reg  [1:0] slot;
	reg  [2:0] bit_cnt;
	reg  [7:0] rx_byte;
	reg  [7:0] tx_byte;
	reg  [7:0] sub_addr;
	reg  [7:0] own_addr;
	reg        ack_go;

	wire       scl_rise;
	wire       scl_fall;
	wire       start_det;
	wire       stop_det;
	wire [7:0] byte_in;
	wire [7:0] strap_addr;

	// All external pins pass two flip-flops before use.
	pin_sync #(
		.WIDTH(4)
	) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.pin_in  ({addr_strap_hi, addr_strap_lo, sda_in, scl_in}),
		.pin_out (pins_sync)
	);

	assign scl_s      = pins_sync[0];
	assign sda_s      = pins_sync[1];
	assign strap_lo_s = pins_sync[2];
	assign strap_hi_s = pins_sync[3];

	// Previous synchronised levels for edge detection.
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_q <= `PIN_IDLE_LEVEL;
			sda_q <= `PIN_IDLE_LEVEL;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// Both lines share the same sync delay, so SDA edges with SCL high are conditions.
	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	assign start_det = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

	// Byte as it stands after the bit sampled on this rising edge, MSB first.
	assign byte_in = {rx_byte[6:0], sda_s};

	// Address byte from the straps; a strap tied low sets its address bit.
	assign strap_addr = `DEV_ADDR_BASE
		| ({7'h00, ~strap_lo_s} << `STRAP_LO_BIT)
		| ({7'h00, ~strap_hi_s} << `STRAP_HI_BIT);

	// Bus occupancy follows start and stop only.
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bus_busy <= 1'b0;
		end else if (start_det) begin
			bus_busy <= 1'b1;
		end else if (stop_det) begin
			bus_busy <= 1'b0;
		end
	end

	// The own address is caught from the straps at every start.
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			own_addr <= `DEV_ADDR_BASE;
		end else if (start_det) begin
			own_addr <= strap_addr;
		end
	end

	// Main protocol engine: bit counting, byte decode and acknowledge slots.
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state       <= ST_IDLE;
			slot        <= SL_DATA;
			bit_cnt     <= `BIT_CNT_FIRST;
			rx_byte     <= 8'h00;
			tx_byte     <= 8'h00;
			sub_addr    <= 8'h00;
			reg_sel     <= 3'h0;
			wr_data     <= 8'h00;
			wr_stb      <= 1'b0;
			rd_stb      <= 1'b0;
			ack_go      <= 1'b0;
			sda_oe      <= 1'b0;
			sda_out     <= 1'b0;
			addressed   <= 1'b0;
			sub_pad_err <= 1'b0;
		end else begin
			wr_stb  <= 1'b0;
			rd_stb  <= 1'b0;
			sda_out <= 1'b0;
			if (start_det) begin
				// A start or repeated start restarts the address phase.
				// The subaddress is deliberately kept for a read that follows.
				state     <= ST_ADDR;
				slot      <= SL_DATA;
				bit_cnt   <= `BIT_CNT_FIRST;
				sda_oe    <= 1'b0;
				ack_go    <= 1'b0;
				addressed <= 1'b0;
			end else if (stop_det) begin
				// A stop ends everything and frees the data line.
				state   <= ST_IDLE;
				slot    <= SL_DATA;
				bit_cnt <= `BIT_CNT_FIRST;
				sda_oe  <= 1'b0;
				ack_go  <= 1'b0;
			end else if (state != ST_IDLE && state != ST_IGNORE) begin
				if (scl_rise) begin
					if (slot == SL_DATA) begin
						rx_byte <= byte_in;
						if (bit_cnt == `BIT_CNT_LAST) begin
							// Eighth bit taken: decide the answer for the slot.
							bit_cnt <= `BIT_CNT_FIRST;
							slot    <= SL_LOW;
							case (state)
								ST_ADDR: begin
									if (byte_in[7:1] == own_addr[7:1]) begin
										ack_go    <= 1'b1;
										addressed <= 1'b1;
										if (byte_in[0]) begin
											state  <= ST_RDATA;
											rd_stb <= 1'b1;
										end else begin
											state <= ST_SUB;
										end
									end else begin
										ack_go <= 1'b0;
										state  <= ST_IGNORE;
									end
								end
								ST_SUB: begin
									// Plain byte; the select field picks the register, the low pad bits only set sub_pad_err.
									sub_addr    <= byte_in;
									reg_sel     <= byte_in[`SUB_SEL_MSB:`SUB_SEL_LSB];
									sub_pad_err <= |byte_in[`SUB_PAD_MSB:0];
									ack_go      <= 1'b1;
									state       <= ST_WDATA;
								end
								ST_WDATA: begin
									// Each byte goes to the selected register while wr_ready is high; otherwise it is refused.
									if (wr_ready) begin
										wr_data <= byte_in;
										wr_stb  <= 1'b1;
										ack_go  <= 1'b1;
									end else begin
										ack_go <= 1'b0;
									end
								end
								default: begin
									// Transmitting: the master answers in this slot.
									ack_go <= 1'b0;
								end
							endcase
						end else begin
							bit_cnt <= bit_cnt + 3'h1;
						end
					end else if (slot == SL_LOW) begin
						// Master clocks the slot; while reading, its answer is sampled.
						slot <= SL_HIGH;
						if (state == ST_RDATA && ack_go == 1'b0) begin
							if (!sda_s) begin
								rd_stb <= 1'b1;
							end else begin
								state <= ST_IGNORE;
							end
						end
					end
				end else if (scl_fall) begin
					if (slot == SL_LOW) begin
						// Pull low for the whole acknowledge pulse, or release.
						sda_oe <= ack_go;
					end else if (slot == SL_HIGH) begin
						slot   <= SL_DATA;
						ack_go <= 1'b0;
						if (state == ST_RDATA) begin
							// First bit of the next read byte, most significant first.
							tx_byte <= rd_data;
							sda_oe  <= ~rd_data[7];
						end else begin
							sda_oe <= 1'b0;
						end
					end else if (state == ST_RDATA) begin
						// Further bits change only while SCL is low.
						sda_oe <= ~tx_byte[`BIT_CNT_LAST - bit_cnt];
					end
				end
			end else begin
				// Idle or not addressed: never touch the data line.
				sda_oe <= 1'b0;
				ack_go <= 1'b0;
			end
		end
	end

endmodule // i2c_slave_port

// ===== common/i2c_port_map.vh
`ifndef I2C_PORT_MAP_VH
`define I2C_PORT_MAP_VH

// Address byte with both straps high; straps that read low set further bits.
`define DEV_ADDR_BASE    8'h90
`define STRAP_LO_BIT     1
`define STRAP_HI_BIT     3

// Field positions of the subaddress byte.
`define SUB_SEL_MSB      5
`define SUB_SEL_LSB      3
`define SUB_PAD_MSB      2

// Bit counter limits within one byte.
`define BIT_CNT_LAST     3'h7
`define BIT_CNT_FIRST    3'h0

// Reset level of the pin synchronisers: a released bus reads high.
`define PIN_IDLE_LEVEL   1'b1

`endif

// ===== rtl/pin_sync.v
`timescale 1ns/1ps
`include "i2c_port_map.vh"

// Two-stage synchroniser for a group of asynchronous pins.
module pin_sync #(
	parameter WIDTH = 4
) (
	input  wire             clk_sys, // System clock.
	input  wire             nrst,    // Asynchronous reset, active low.
	input  wire [WIDTH-1:0] pin_in,  // Raw pin levels.
	output wire [WIDTH-1:0] pin_out  // Synchronised pin levels.
);

	genvar i;

	// One pair of flip-flops per pin; only the second stage is visible outside.
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta;
			reg stable;
			always @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					meta   <= `PIN_IDLE_LEVEL;
					stable <= `PIN_IDLE_LEVEL;
				end else begin
					meta   <= pin_in[i];
					stable <= meta;
				end
			end
			assign pin_out[i] = stable;
		end
	endgenerate

endmodule // pin_sync

// ===== dv/bus_master.sv
`timescale 1ns/1ps
// Two-wire bus master; SCL period 320 ns, a released line reads high.
module bus_master (
	output logic scl,   // Serial clock.
	output logic sda_m, // Master data level, 1 releases.
	input  wire  sda    // Wired data line.
);
	// The bus idles released.
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// Start and repeated start: SDA falls while SCL is high.
	task automatic start();
		#80 sda_m = 1'b1;
		#80 scl = 1'b1;
		#80 sda_m = 1'b0;
		#80 scl = 1'b0;
	endtask
	// Stop: SDA rises while SCL is high.
	task automatic stop();
		#80 sda_m = 1'b0;
		#80 scl = 1'b1;
		#80 sda_m = 1'b1;
		// The slave sees the stop three clocks late; the free bus time covers that.
		#160;
	endtask
	// One bit; data changes only while SCL is low.
	task automatic bit_x(input logic b, output logic r);
		#80 sda_m = b;
		#80 scl = 1'b1;
		#80 r = sda;
		#80 scl = 1'b0;
	endtask
	// One byte MSB first plus the acknowledge slot.
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(ak, a);
	endtask
endmodule // bus_master

// ===== dv/i2c_slave_port_monitor.sv
`timescale 1ns/1ps
// Timing relations between the pins and the strobes of the slave port.
module i2c_slave_port_monitor (
	input wire       clk_sys,  // System clock.
	input wire       nrst,     // Reset, active low.
	input wire       scl_in,   // Serial clock level.
	input wire       sda_in,   // Serial data level.
	input wire       sda_out,  // Data drive level.
	input wire       sda_oe,   // Data pull-down enable.
	input wire [2:0] reg_sel,  // Register index.
	input wire       wr_stb,   // Write strobe.
	input wire       wr_ready, // Register side ready.
	input wire       rd_stb,   // Read request.
	input wire       bus_busy, // Bus occupied.
	input wire       addressed // Slave selected.
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_start_busy: assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] bus_busy)
		else $error("busy missing after start");
	a_stop_free: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] !bus_busy)
		else $error("busy kept after stop");
	a_oe_addr: assert property ($rose(sda_oe) |-> addressed)
		else $error("drive without address match");
	a_oe_pull: assert property (sda_oe |-> !sda_out && bus_busy)
		else $error("drive not low or bus free");
	a_oe_edge: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data changed with clock high");
	a_wr_pulse: assert property (wr_stb |=> !wr_stb)
		else $error("write strobe too long");
	a_wr_ready: assert property (wr_stb |-> wr_ready)
		else $error("write while not ready");
	a_rd_pulse: assert property (rd_stb |=> !rd_stb)
		else $error("read strobe too long");
	a_sel_hold: assert property ($changed(reg_sel) |-> bus_busy && addressed)
		else $error("select changed outside access");
endmodule // i2c_slave_port_monitor

bind i2c_slave_port i2c_slave_port_monitor i2c_slave_port_monitor_i (.clk_sys, .nrst, .scl_in,
	.sda_in, .sda_out, .sda_oe, .reg_sel, .wr_stb, .wr_ready, .rd_stb, .bus_busy, .addressed);

// ===== dv/tb_i2c_slave_port.sv
`timescale 1ns/1ps
// Self-checking bench for the two-wire slave port.
module tb_i2c_slave_port;
	logic       clk_sys, nrst, addr_strap_hi, addr_strap_lo, wr_ready, sda_m, scl_in;
	logic       sda_out, sda_oe, wr_stb, rd_stb, bus_busy, addressed, sub_pad_err;
	logic [2:0] reg_sel;
	logic [7:0] wr_data, rd_data;
	logic [7:0] wr_cnt = 8'h0;
	logic [7:0] rd_cnt = 8'h0;
	wire        sda_in;
	int         miscompares = 0;
	int         checked = 0;
	int         cycles = 0;

	// Open-drain wire with pull-up.
	assign sda_in = sda_m & ~(sda_oe & ~sda_out);
	// Register side: read byte carries the selected index and a running count.
	assign rd_data = {reg_sel, rd_cnt[4:0]};

	i2c_slave_port i2c_slave_port_i (.clk_sys, .nrst, .scl_in, .sda_in, .sda_out, .sda_oe,
		.addr_strap_hi, .addr_strap_lo, .reg_sel, .wr_data, .wr_stb, .wr_ready, .rd_stb,
		.rd_data, .bus_busy, .addressed, .sub_pad_err);
	bus_master bus_master_i (.scl(scl_in), .sda_m, .sda(sda_in));

	// Clock and strobe counters; a hang ends the run.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		wr_cnt <= wr_cnt + 8'(wr_stb);
		rd_cnt <= rd_cnt + 8'(rd_stb);
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			miscompares++;
			end_sim();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [7:0] d, input logic e);
		logic [7:0] q;
		logic a;
		bus_master_i.xfer(d, 1'b1, q, a);
		chk({7'h0, a}, {7'h0, e});
	endtask
	task automatic end_sim();
		if (miscompares == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Two-byte writes under every strap setting, stray upper subaddress bits set.
	task automatic t_write();
		logic [7:0] ad [4] = '{8'h90, 8'h92, 8'h98, 8'h9a};
		logic [7:0] n;
		for (int s = 0; s < 4; s++) begin
			{addr_strap_hi, addr_strap_lo} = 2'(3 - s);
			n = wr_cnt;
			bus_master_i.start();
			wb(ad[s], 1'b0);
			chk({7'h0, addressed}, 8'h1);
			wb(8'hc0 | 8'(s << 3), 1'b0);
			wb(8'h11 * 8'(s), 1'b0);
			chk(wr_data, 8'h11 * 8'(s));
			wb(8'h5a, 1'b0);
			chk(wr_data, 8'h5a);
			chk(wr_cnt, n + 8'h2);
			bus_master_i.stop();
			chk({5'h0, reg_sel}, 8'(s));
			chk({7'h0, sub_pad_err}, 8'h0);
			chk({7'h0, bus_busy}, 8'h0);
		end
	endtask
	// Register read after a repeated start, two bytes, the last refused.
	task automatic t_read();
		logic [7:0] q, c;
		logic a;
		bus_master_i.start();
		wb(8'h9a, 1'b0);
		wb(8'h28, 1'b0);
		bus_master_i.start();
		wb(8'h9b, 1'b0);
		c = rd_cnt;
		bus_master_i.xfer(8'hff, 1'b0, q, a);
		chk(q, {3'h5, c[4:0]});
		bus_master_i.xfer(8'hff, 1'b1, q, a);
		chk(q, {3'h5, 5'(c[4:0] + 5'h1)});
		repeat (6) @(negedge clk_sys);
		chk({7'h0, sda_oe}, 8'h0);
		bus_master_i.stop();
	endtask
	// Byte refused when not ready, then a foreign address left alone.
	task automatic t_refuse();
		logic [7:0] n;
		wr_ready = 1'b0;
		n = wr_cnt;
		bus_master_i.start();
		wb(8'h9a, 1'b0);
		wb(8'h09, 1'b0);
		chk({7'h0, sub_pad_err}, 8'h1);
		wb(8'h77, 1'b1);
		chk(wr_cnt, n);
		bus_master_i.stop();
		wr_ready = 1'b1;
		addr_strap_hi = 1'b1;
		addr_strap_lo = 1'b1;
		bus_master_i.start();
		wb(8'h9a, 1'b1);
		wb(8'h08, 1'b1);
		chk({7'h0, addressed}, 8'h0);
		bus_master_i.stop();
	endtask

	// Reset, then the scenarios.
	initial begin
		nrst = 1'b0;
		addr_strap_hi = 1'b1;
		addr_strap_lo = 1'b1;
		wr_ready = 1'b1;
		repeat (2) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (3) @(negedge clk_sys);
		t_write();
		t_read();
		t_refuse();
		end_sim();
	end
endmodule // tb_i2c_slave_port
